// ===== shared/power_boot_pkg.sv
// Constants and types for the power control and startup configuration registers
package power_boot_pkg;

    // Register byte offsets
    localparam logic [7:0]  STARTUP_CFG_OFFSET = 8'h50;
    localparam logic [7:0]  POWER_CTRL_OFFSET  = 8'h54;

    // Reset values
    localparam logic [15:0] STARTUP_CFG_RESET = 16'h0000;
    localparam logic [15:0] POWER_CTRL_RESET  = 16'h0000;

    // Startup configuration fields
    localparam int USB_FILT_BIT  = 3;
    localparam int SERIAL0_BIT   = 2;
    localparam int BOOT_LSB      = 0;
    localparam int BOOT_MSB      = 1;

    // Startup memory encodings
    localparam logic [1:0]  BOOT_FLASH    = 2'h0;
    localparam logic [1:0]  BOOT_SYSMEM   = 2'h1;
    localparam logic [1:0]  BOOT_RAM      = 2'h2;
    localparam logic [1:0]  BOOT_EXTERNAL = 2'h3;

    // Power control fields
    localparam int UNLOCK_BIT    = 15;
    localparam int BUSY_BIT      = 14;
    localparam int WAKE_BIT      = 13;
    localparam int VSTABLE_BIT   = 12;
    localparam int FLASH_LOW_POWER_SELECT_BIT  = 9;
    localparam int UV_DIS_BIT    = 8;
    localparam int SLOW_OSC_BYPASS_BIT   = 7;
    localparam int PWR_DOWN_BIT  = 6;
    localparam int BKP_BYP_BIT   = 5;
    localparam int BKP_LP_BIT    = 4;
    localparam int MAIN_BYP_BIT  = 3;

    // Unlock window and flash low-power ceiling
    localparam int UNLOCK_CYCLES    = 64;
    localparam int FLASH_LOW_POWER_SELECT_MAX_MHZ = 33;

    // Pin synchroniser lanes
    localparam int PIN_COUNT     = 7;
    localparam int PIN_BOOT0     = 0;
    localparam int PIN_BOOT1     = 1;
    localparam int PIN_WAKE      = 2;
    localparam int PIN_INT_WAKE  = 3;
    localparam int PIN_VSTABLE   = 4;
    localparam int PIN_ACK       = 5;
    localparam int PIN_USB_STBY  = 6;
    localparam logic [1:0] BOOT_SETTLE = 2'h3;

    // Backup write handshake states
    typedef enum logic [1:0] {
        HS_IDLE = 2'b01,
        HS_WAIT = 2'b10
    } hs_state_type;

endpackage

// ===== core/power_boot_config_regs.sv
// Power control and startup configuration registers behind an APB slave
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps

module power_boot_config_regs
    import power_boot_pkg::*;
#(
    parameter int ADDR_W        = 8,
    parameter int UNLOCK_WINDOW = UNLOCK_CYCLES
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [1:0]        bootPins,
    input  wire logic              wakePin,
    input  wire logic              internalWake,
    input  wire logic              regulatorStable,
    input  wire logic              backupAck,
    input  wire logic              usbStandby,
    input  wire logic              lowPowerMode,
    output logic                   usbFilterActive,
    output logic                   serialPortZeroActive,
    output logic                   sharedPinsForOthers,
    output logic [1:0]             bootAliasSelect,
    output logic                   flashBurstEnable,
    output logic                   flashWaitOnNonSeq,
    output logic                   undervoltageResetEnable,
    output logic                   slowOscRunning,
    output logic                   powerDownActive,
    output logic                   mainRegulatorOn,
    output logic                   backupRegulatorOn,
    output logic                   coreExternalSupply,
    output logic                   backupWriteToggle
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Filtered level follows once two late stages agree
    function automatic logic [PIN_COUNT-1:0] agree_filter(
        input logic [PIN_COUNT-1:0] b,
        input logic [PIN_COUNT-1:0] c,
        input logic [PIN_COUNT-1:0] held
    );
        agree_filter = (b & c) | (held & (b ^ c));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [PIN_COUNT-1:0] syncA_reg;
    logic [PIN_COUNT-1:0] syncB_reg;
    logic [PIN_COUNT-1:0] syncC_reg;
    logic [PIN_COUNT-1:0] pinLevel_reg;
    logic [PIN_COUNT-1:0] pinLevel_next;
    logic [PIN_COUNT-1:0] pinRaw;

    assign pinRaw = {usbStandby, backupAck, regulatorStable,
                     internalWake, wakePin, bootPins[1], bootPins[0]};

    // Agreement filter after the third stage
    always_comb begin
        pinLevel_next = agree_filter(syncB_reg, syncC_reg, pinLevel_reg);
    end

    // Three stage chain
    always_ff @(posedge mclk) begin
        if (rst) begin
            syncA_reg    <= '0;
            syncB_reg    <= '0;
            syncC_reg    <= '0;
            pinLevel_reg <= '0;
        end else begin
            syncA_reg    <= pinRaw;
            syncB_reg    <= syncA_reg;
            syncC_reg    <= syncB_reg;
            pinLevel_reg <= pinLevel_next;
        end
    end

    logic wakeActive;
    assign wakeActive = pinLevel_reg[PIN_WAKE] | pinLevel_reg[PIN_INT_WAKE];

    ////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state

    logic        pready_reg;
    logic        pready_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pslverr_reg;
    logic        pslverr_next;
    logic        hitStartup;
    logic        hitPower;
    logic        writeStrobe;
    logic [15:0] startupRead;
    logic [15:0] powerRead;

    assign hitStartup  = (paddr[7:0] == STARTUP_CFG_OFFSET);
    assign hitPower    = (paddr[7:0] == POWER_CTRL_OFFSET);
    assign writeStrobe = psel & penable & pready_reg & pwrite;

    // Answer one cycle into the access phase
    always_comb begin
        pready_next  = 1'b0;
        prdata_next  = prdata_reg;
        pslverr_next = 1'b0;
        if (psel && penable && !pready_reg) begin
            pready_next  = 1'b1;
            pslverr_next = !(hitStartup || hitPower);
            prdata_next  = 32'h0000_0000;
            if (!pwrite && hitStartup) begin
                prdata_next = {16'h0000, startupRead};
            end else if (!pwrite && hitPower) begin
                prdata_next = {16'h0000, powerRead};
            end
        end
    end

    // Bus answer registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= pready_next;
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign pready  = pready_reg;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;

    ////////////////////////////////////////////////////////////////////////
    // Startup configuration

    logic [3:0] startup_reg;
    logic [3:0] startup_next;
    logic [1:0] settle_reg;
    logic [1:0] settle_next;
    logic       bootLoaded_reg;
    logic       bootLoaded_next;

    assign startupRead = {12'h000, startup_reg};

    // Boot pins caught once the chain has settled after release
    always_comb begin
        startup_next    = startup_reg;
        settle_next     = settle_reg;
        bootLoaded_next = bootLoaded_reg;
        if (!bootLoaded_reg) begin
            if (settle_reg == BOOT_SETTLE) begin
                startup_next[BOOT_MSB:BOOT_LSB] =
                    {pinLevel_next[PIN_BOOT1], pinLevel_next[PIN_BOOT0]};
                bootLoaded_next = 1'b1;
            end else begin
                settle_next = settle_reg + 2'h1;
            end
        end else if (writeStrobe && hitStartup) begin
            startup_next = pwdata[3:0];
        end
    end

    // Startup configuration registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            startup_reg    <= STARTUP_CFG_RESET[3:0];
            settle_reg     <= 2'h0;
            bootLoaded_reg <= 1'b0;
        end else begin
            startup_reg    <= startup_next;
            settle_reg     <= settle_next;
            bootLoaded_reg <= bootLoaded_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power control

    logic       unlock_reg;
    logic       unlock_next;
    logic [6:0] unlockCnt_reg;
    logic [6:0] unlockCnt_next;
    logic [6:0] powerBits_reg;
    logic [6:0] powerBits_next;
    logic       powerWrite;
    logic       busy;

    // Stored bits: flash_low_power_select, uv dis, slow_osc_bypass, pwr dn, bkp byp, bkp lp, main byp
    localparam int PB_FLASH = 6;
    localparam int PB_UV    = 5;
    localparam int PB_OSC   = 4;
    localparam int PB_PD    = 3;
    localparam int PB_BBYP  = 2;
    localparam int PB_BLP   = 1;
    localparam int PB_MBYP  = 0;
    localparam logic [6:0] UNLOCK_LAST = 7'(UNLOCK_WINDOW - 1);

    assign powerWrite = writeStrobe && hitPower && !busy;

    assign powerRead = {unlock_reg, busy, wakeActive,
                        pinLevel_reg[PIN_VSTABLE],
                        2'b00,
                        powerBits_reg,
                        3'b000};

    // Unlock window and locked writes
    always_comb begin
        unlock_next    = unlock_reg;
        unlockCnt_next = unlockCnt_reg;
        powerBits_next = powerBits_reg;
        if (unlock_reg) begin
            if (unlockCnt_reg == UNLOCK_LAST) begin
                unlock_next    = 1'b0;
                unlockCnt_next = 7'h00;
            end else begin
                unlockCnt_next = unlockCnt_reg + 7'h01;
            end
        end
        if (powerWrite) begin
            if (pwdata[UNLOCK_BIT] && !unlock_reg) begin
                unlock_next    = 1'b1;
                unlockCnt_next = 7'h00;
            end
            if (pwdata[UNLOCK_BIT]) begin
                powerBits_next[PB_FLASH] = pwdata[FLASH_LOW_POWER_SELECT_BIT];
            end
            if (unlock_reg) begin
                powerBits_next[PB_UV] = powerBits_reg[PB_UV]
                                      | pwdata[UV_DIS_BIT];
                powerBits_next[PB_OSC]  = pwdata[SLOW_OSC_BYPASS_BIT];
                powerBits_next[PB_BBYP] = pwdata[BKP_BYP_BIT];
                powerBits_next[PB_BLP]  = pwdata[BKP_LP_BIT];
                powerBits_next[PB_MBYP] = pwdata[MAIN_BYP_BIT];
                if (!pwdata[PWR_DOWN_BIT] || !wakeActive) begin
                    powerBits_next[PB_PD] = pwdata[PWR_DOWN_BIT];
                end
            end
        end
    end

    // Power control registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            unlock_reg    <= POWER_CTRL_RESET[UNLOCK_BIT];
            unlockCnt_reg <= 7'h00;
            powerBits_reg <= POWER_CTRL_RESET[9:3];
        end else begin
            unlock_reg    <= unlock_next;
            unlockCnt_reg <= unlockCnt_next;
            powerBits_reg <= powerBits_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Backup logic handshake

    hs_state_type hsState_reg;
    hs_state_type hsState_next;
    logic         reqToggle_reg;
    logic         reqToggle_next;
    logic         ackSeen_reg;
    logic         ackSeen_next;

    assign busy = (hsState_reg == HS_WAIT);

    // Toggle out per accepted write, wait for ack toggle back
    always_comb begin
        hsState_next   = hsState_reg;
        reqToggle_next = reqToggle_reg;
        ackSeen_next   = ackSeen_reg;
        unique case (hsState_reg)
            HS_IDLE: begin
                if (powerWrite) begin
                    reqToggle_next = !reqToggle_reg;
                    hsState_next   = HS_WAIT;
                end
            end
            HS_WAIT: begin
                if (pinLevel_reg[PIN_ACK] != ackSeen_reg) begin
                    ackSeen_next = pinLevel_reg[PIN_ACK];
                    hsState_next = HS_IDLE;
                end
            end
            default: begin
                hsState_next = HS_IDLE;
            end
        endcase
    end

    // Handshake registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            hsState_reg   <= HS_IDLE;
            reqToggle_reg <= 1'b0;
            ackSeen_reg   <= 1'b0;
        end else begin
            hsState_reg   <= hsState_next;
            reqToggle_reg <= reqToggle_next;
            ackSeen_reg   <= ackSeen_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered control outputs

    logic [13:0] ctrl_reg;
    logic [13:0] ctrl_next;
    logic        pdEffective;

    assign pdEffective = powerBits_reg[PB_PD] & !wakeActive;

    // Decode of stored bits into control levels
    always_comb begin
        ctrl_next[0]    = startup_reg[USB_FILT_BIT]
                        & pinLevel_reg[PIN_USB_STBY];
        ctrl_next[1]    = startup_reg[SERIAL0_BIT];
        ctrl_next[2]    = !startup_reg[SERIAL0_BIT];
        ctrl_next[4:3]  = startup_reg[BOOT_MSB:BOOT_LSB];
        ctrl_next[5]    = !powerBits_reg[PB_FLASH];
        ctrl_next[6]    = !powerBits_reg[PB_FLASH];
        ctrl_next[7]    = !powerBits_reg[PB_UV];
        ctrl_next[8]    = !powerBits_reg[PB_OSC];
        ctrl_next[9]    = pdEffective;
        ctrl_next[10]   = !pdEffective
                        & !powerBits_reg[PB_MBYP]
                        & !(powerBits_reg[PB_BLP]
                            & lowPowerMode);
        ctrl_next[11]   = !powerBits_reg[PB_BBYP];
        ctrl_next[12]   = powerBits_reg[PB_MBYP];
        ctrl_next[13]   = reqToggle_reg;
    end

    // Output flops
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_reg <= 14'h0DE4;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    assign usbFilterActive         = ctrl_reg[0];
    assign serialPortZeroActive    = ctrl_reg[1];
    assign sharedPinsForOthers     = ctrl_reg[2];
    assign bootAliasSelect         = ctrl_reg[4:3];
    assign flashBurstEnable        = ctrl_reg[5];
    assign flashWaitOnNonSeq       = ctrl_reg[6];
    assign undervoltageResetEnable = ctrl_reg[7];
    assign slowOscRunning          = ctrl_reg[8];
    assign powerDownActive         = ctrl_reg[9];
    assign mainRegulatorOn         = ctrl_reg[10];
    assign backupRegulatorOn       = ctrl_reg[11];
    assign coreExternalSupply      = ctrl_reg[12];
    assign backupWriteToggle       = ctrl_reg[13];

endmodule

// ===== tb/power_boot_config_regs_asserts.sv
// Concurrent checks on the power control and startup configuration ports
`timescale 1ns/1ps
module power_boot_config_regs_chk
    import power_boot_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              wakePin,
    input wire logic              usbStandby,
    input wire logic              usbFilterActive,
    input wire logic              serialPortZeroActive,
    input wire logic              sharedPinsForOthers,
    input wire logic              flashBurstEnable,
    input wire logic              flashWaitOnNonSeq,
    input wire logic              undervoltageResetEnable,
    input wire logic              powerDownActive,
    input wire logic              mainRegulatorOn,
    input wire logic              coreExternalSupply
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus timing and reserved read bits
    chk_ready_after_wait: assert property (psel && penable && !pready |=> pready)
        else $error("ready missing after one wait state");
    chk_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    chk_error_with_ready: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    chk_reserved_read_zero: assert property (pready && !pwrite && paddr == POWER_CTRL_OFFSET
        |-> prdata[31:16] == 16'h0000 && prdata[11:10] == 2'h0 && prdata[2:0] == 3'h0)
        else $error("reserved power bits not zero");

    ////////////////////////////////////////////////////////////////////////////////
    // Control outputs
    chk_usb_filter_idle: assert property (!usbStandby [*8] |-> !usbFilterActive)
        else $error("filter on outside standby");
    chk_pins_exclusive: assert property (serialPortZeroActive != sharedPinsForOthers)
        else $error("shared pins owned twice");
    chk_flash_modes_pair: assert property (flashBurstEnable == flashWaitOnNonSeq)
        else $error("burst and wait disagree");
    chk_wake_blocks_down: assert property (wakePin [*8] |-> !powerDownActive)
        else $error("power-down while wake active");
    chk_down_main_off: assert property (powerDownActive |-> !mainRegulatorOn)
        else $error("main regulator on in power-down");
    chk_bypass_main_off: assert property (coreExternalSupply |-> !mainRegulatorOn)
        else $error("main regulator on in bypass");
    chk_uv_disable_sticky: assert property (!undervoltageResetEnable |=> !undervoltageResetEnable)
        else $error("detector disable cleared");

    // Main scenarios reached
    cover property ($rose(powerDownActive));
    cover property (pslverr);
    cover property ($fell(undervoltageResetEnable));
endmodule

bind power_boot_config_regs power_boot_config_regs_chk #(.ADDR_W(ADDR_W)) u_chk (
    .mclk, .rst, .paddr, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
    .wakePin, .usbStandby, .usbFilterActive, .serialPortZeroActive,
    .sharedPinsForOthers, .flashBurstEnable, .flashWaitOnNonSeq,
    .undervoltageResetEnable, .powerDownActive, .mainRegulatorOn, .coreExternalSupply
);

// ===== tb/power_boot_config_regs_test.sv
// Self-checking bench for the power control and startup registers
`timescale 1ns/1ps
module power_boot_config_regs_test
    import power_boot_pkg::*;
;
    logic        mclk, rst, psel, penable, pwrite, pready, pslverr, lastErr;
    logic        wakePin, internalWake, regulatorStable, backupAck, usbStandby, lowPowerMode;
    logic        usbFilterActive, serialPortZeroActive, sharedPinsForOthers, flashBurstEnable;
    logic        flashWaitOnNonSeq, undervoltageResetEnable, slowOscRunning, powerDownActive;
    logic        mainRegulatorOn, backupRegulatorOn, coreExternalSupply, backupWriteToggle;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  bootPins, bootAliasSelect;
    logic [2:0]  ackPipe;
    int          badCount = 0;
    int          checksDone = 0;

    power_boot_config_regs #(.ADDR_W(8), .UNLOCK_WINDOW(64)) i_dut (
        .mclk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .bootPins, .wakePin, .internalWake, .regulatorStable, .backupAck, .usbStandby,
        .lowPowerMode, .usbFilterActive, .serialPortZeroActive, .sharedPinsForOthers,
        .bootAliasSelect, .flashBurstEnable, .flashWaitOnNonSeq, .undervoltageResetEnable,
        .slowOscRunning, .powerDownActive, .mainRegulatorOn, .backupRegulatorOn,
        .coreExternalSupply, .backupWriteToggle
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Backup logic echoes each write toggle a few cycles later
    always @(posedge mclk) begin
        if (rst) begin
            ackPipe   <= 3'h0;
            backupAck <= 1'b0;
        end else begin
            ackPipe   <= {ackPipe[1:0], backupWriteToggle};
            backupAck <= ackPipe[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            badCount++;
            $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // One APB transfer, held until ready is sampled high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1);
        check(n, 32'h2);
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    // Read power control once the backup handshake is idle
    task automatic rdq();
        rd = 32'h0000_4000;
        while (rd[BUSY_BIT] !== 1'b0) apb(POWER_CTRL_OFFSET, 1'b0, 32'h0);
    endtask

    task automatic pw(input logic [31:0] d);
        rdq();
        apb(POWER_CTRL_OFFSET, 1'b1, d);
    endtask

    task automatic closeOut();
        if (badCount == 0 && checksDone > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Tests
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} <= {4'h8, 8'h00, 32'h0};
        {bootPins, wakePin, internalWake, regulatorStable} <= 5'h11;
        {usbStandby, lowPowerMode} <= 2'h3;
        tick(3);
        rst <= 1'b0;
        tick(8);
        apb(STARTUP_CFG_OFFSET, 1'b0, 32'h0);
        check(rd, 32'h2);
        check({30'h0, bootAliasSelect}, 32'h2);
        for (int k = 0; k < 4; k++) begin
            apb(STARTUP_CFG_OFFSET, 1'b1, 32'hFFFF_FFF0 | {28'h0, k[1:0], k[1:0]});
            apb(STARTUP_CFG_OFFSET, 1'b0, 32'h0);
            check(rd, {28'h0, k[1:0], k[1:0]});
            check({30'h0, bootAliasSelect}, {30'h0, k[1:0]});
            check({30'h0, serialPortZeroActive, sharedPinsForOthers}, {30'h0, k[0], !k[0]});
            check({31'h0, usbFilterActive}, {31'h0, k[1]});
        end
        usbStandby <= 1'b0;
        tick(8);
        check({31'h0, usbFilterActive}, 32'h0);
        apb(8'h58, 1'b0, 32'h0);
        check({lastErr, rd[30:0]}, 32'h8000_0000);
        rdq();
        check(rd, 32'h1000);
        pw(32'h01F8);
        rdq();
        check(rd, 32'h1000);
        // First window: busy refusal and low-power regulator select
        pw(32'h8000);
        apb(POWER_CTRL_OFFSET, 1'b1, 32'h8010);
        rdq();
        check(rd, 32'h9000);
        pw(32'h8010);
        tick(3);
        check({31'h0, mainRegulatorOn}, 32'h0);
        lowPowerMode <= 1'b0;
        tick(3);
        check({31'h0, mainRegulatorOn}, 32'h1);
        tick(70);
        rdq();
        check(rd, 32'h1010);
        // Second window: wake blocks power-down
        wakePin <= 1'b1;
        tick(6);
        rdq();
        check(rd, 32'h3010);
        pw(32'h8000);
        pw(32'h8060);
        tick(3);
        check({31'h0, powerDownActive}, 32'h0);
        wakePin <= 1'b0;
        tick(6);
        pw(32'h8060);
        tick(3);
        check({30'h0, powerDownActive, mainRegulatorOn}, 32'h2);
        // Third window: bypass controls and sticky detector disable
        tick(70);
        pw(32'h8000);
        pw(32'hFFFF_8DAF);
        tick(3);
        check({25'h0, undervoltageResetEnable, slowOscRunning, backupRegulatorOn,
               coreExternalSupply, mainRegulatorOn, flashBurstEnable, powerDownActive},
              32'h0A);
        rdq();
        check(rd, 32'h91A8);
        pw(32'h0);
        rdq();
        check(rd, 32'h9100);
        tick(70);
        pw(32'h0208);
        rdq();
        check(rd, 32'h1100);
        pw(32'h8200);
        rdq();
        check(rd, 32'h9300);
        check({30'h0, flashBurstEnable, flashWaitOnNonSeq}, 32'h0);
        rst <= 1'b1;
        tick(3);
        rst <= 1'b0;
        tick(8);
        rdq();
        check(rd, 32'h1000);
        check({31'h0, undervoltageResetEnable}, 32'h1);
        closeOut();
    end

    // Watchdog
    initial begin
        tick(4000);
        badCount++;
        closeOut();
    end
endmodule
